// ### common/cptm_pkg.sv
// Package with constants, register map and enumerations of the counter block.
package cptm_pkg;
    localparam int unsigned DATA_W = 32;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_RESULT = 12'h008;
    localparam logic [11:0] OFF_DELAY = 12'h00c;
    localparam logic [11:0] OFF_HIGH = 12'h010;
    localparam logic [11:0] OFF_LOW = 12'h014;
    localparam logic [11:0] OFF_COUNT = 12'h018;
    localparam logic [11:0] OFF_START = 12'h01c;
    // Control field positions.
    localparam int unsigned CTL_MODE_LSB = 0;
    localparam int unsigned CTL_POL_A = 3;
    localparam int unsigned CTL_POL_B = 4;
    localparam int unsigned CTL_IDLE_HI = 5;
    localparam int unsigned CTL_EXT_TB = 6;
    localparam int unsigned CTL_MEAS_EN = 7;
    localparam int unsigned CTL_W = 8;
    // Status field positions.
    localparam int unsigned ST_VALID = 0;
    localparam int unsigned ST_BUSY = 1;
    localparam int unsigned ST_OVF = 2;
    localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_ONE = 32'h0000_0001;
    localparam logic [2:0] MODE_PERIOD = 3'h0;
    localparam logic [2:0] MODE_SEMI = 3'h1;
    localparam logic [2:0] MODE_WIDTH = 3'h2;
    localparam logic [2:0] MODE_TWOEDGE = 3'h3;
    typedef enum logic [1:0] {
        GEN_IDLE,
        GEN_DELAY,
        GEN_ACTIVE,
        GEN_REST
    } cptm_gen_t;
endpackage : cptm_pkg

// ### rtl/cptm_top.sv
// Counter with pulse and time measurement and pulse generation, APB slave.
`timescale 1ns/1ps
module cptm_top #(
    parameter int unsigned CNT_W = 32
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic in_a_i,
    input wire logic in_b_i,
    input wire logic ext_tb_i,
    output logic ctr_out_o
);
    // Synchronisers: first stage feeds only the second.
    logic [2:0] sync1_ff, sync2_ff, prev_ff;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            prev_ff <= 3'h0;
        end else begin
            sync1_ff <= {ext_tb_i, in_b_i, in_a_i};
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    logic a_rise, a_fall, b_rise, b_fall, tb_rise;
    assign a_rise = sync2_ff[0] & ~prev_ff[0];
    assign a_fall = ~sync2_ff[0] & prev_ff[0];
    assign b_rise = sync2_ff[1] & ~prev_ff[1];
    assign b_fall = ~sync2_ff[1] & prev_ff[1];
    assign tb_rise = sync2_ff[2] & ~prev_ff[2];

    // Register file state.
    logic [cptm_pkg::CTL_W-1:0] ctrl_ff, nxt_ctrl;
    logic [31:0] delay_ff, nxt_delay, high_ff, nxt_high;
    logic [31:0] low_ff, nxt_low, count_ff, nxt_count;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic start_req, rd_result;
    logic [2:0] mode;
    logic tick;
    assign mode = ctrl_ff[cptm_pkg::CTL_MODE_LSB +: 3];
    // Selected timebase: every clock or external rising edge.
    assign tick = ctrl_ff[cptm_pkg::CTL_EXT_TB] ? tb_rise : 1'b1;

    // Measurement state.
    logic [CNT_W-1:0] mcnt_ff, nxt_mcnt, result_ff, nxt_result;
    logic valid_ff, nxt_valid, ovf_ff, nxt_ovf, armed_ff, nxt_armed;
    logic open_ev, close_ev;

    // Edge that opens and edge that closes the interval for each mode.
    always_comb begin
        logic pa, pb, ea, eb;
        pa = ctrl_ff[cptm_pkg::CTL_POL_A];
        pb = ctrl_ff[cptm_pkg::CTL_POL_B];
        ea = pa ? a_fall : a_rise;
        eb = pb ? b_fall : b_rise;
        open_ev = 1'b0;
        close_ev = 1'b0;
        unique case (mode)
            cptm_pkg::MODE_PERIOD: begin
                open_ev = ea;
                close_ev = ea;
            end
            cptm_pkg::MODE_SEMI: begin
                open_ev = a_rise | a_fall;
                close_ev = a_rise | a_fall;
            end
            cptm_pkg::MODE_WIDTH: begin
                open_ev = ea;
                close_ev = pa ? a_rise : a_fall;
            end
            cptm_pkg::MODE_TWOEDGE: begin
                open_ev = ea;
                close_ev = eb;
            end
            default: begin
                open_ev = 1'b0;
                close_ev = 1'b0;
            end
        endcase
    end

    // Tick counter with capture on the closing edge.
    always_comb begin
        nxt_mcnt = mcnt_ff;
        nxt_result = result_ff;
        nxt_armed = armed_ff;
        nxt_ovf = ovf_ff;
        nxt_valid = valid_ff;
        if (rd_result) begin
            nxt_valid = 1'b0;
            nxt_ovf = 1'b0;
        end
        if (!ctrl_ff[cptm_pkg::CTL_MEAS_EN]) begin
            nxt_armed = 1'b0;
            nxt_mcnt = '0;
        end else if (armed_ff && close_ev) begin
            // The tick on the closing edge still belongs to the interval.
            nxt_result = (tick && mcnt_ff != '1) ?
                CNT_W'(mcnt_ff + 1'b1) : mcnt_ff;
            nxt_mcnt = '0;
            nxt_ovf = ovf_ff | valid_ff;
            nxt_valid = 1'b1;
            nxt_armed = open_ev;
        end else if (open_ev && !armed_ff) begin
            nxt_armed = 1'b1;
            nxt_mcnt = '0;
        end else if (armed_ff && tick && mcnt_ff != '1) begin
            nxt_mcnt = mcnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mcnt_ff <= '0;
            result_ff <= '0;
            armed_ff <= 1'b0;
            ovf_ff <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            mcnt_ff <= nxt_mcnt;
            result_ff <= nxt_result;
            armed_ff <= nxt_armed;
            ovf_ff <= nxt_ovf;
            valid_ff <= nxt_valid;
        end
    end

    // Pulse generator state.
    cptm_pkg::cptm_gen_t gst_ff, nxt_gst;
    logic [31:0] gcnt_ff, nxt_gcnt, left_ff, nxt_left;
    logic out_ff, nxt_out, idle_hi;
    assign idle_hi = ctrl_ff[cptm_pkg::CTL_IDLE_HI];

    // Phase sequencer: one delay, then active and rest per pulse, no rest after the last.
    always_comb begin
        nxt_gst = gst_ff;
        nxt_gcnt = gcnt_ff;
        nxt_left = left_ff;
        nxt_out = idle_hi;
        unique case (gst_ff)
            cptm_pkg::GEN_IDLE: begin
                if (start_req) begin
                    nxt_gst = cptm_pkg::GEN_DELAY;
                    nxt_gcnt = delay_ff;
                    nxt_left = (count_ff == 32'h0) ? 32'h1 : count_ff;
                end
            end
            cptm_pkg::GEN_DELAY, cptm_pkg::GEN_REST: begin
                nxt_out = idle_hi;
                if (tick) begin
                    if (gcnt_ff <= 32'h1) begin
                        nxt_gst = cptm_pkg::GEN_ACTIVE;
                        nxt_gcnt = idle_hi ? low_ff : high_ff;
                        nxt_out = ~idle_hi;
                    end else begin
                        nxt_gcnt = gcnt_ff - 32'h1;
                    end
                end
            end
            cptm_pkg::GEN_ACTIVE: begin
                nxt_out = ~idle_hi;
                if (tick) begin
                    if (gcnt_ff <= 32'h1) begin
                        nxt_out = idle_hi;
                        if (left_ff <= 32'h1) begin
                            nxt_gst = cptm_pkg::GEN_IDLE;
                            nxt_left = 32'h0;
                        end else begin
                            nxt_gst = cptm_pkg::GEN_REST;
                            nxt_gcnt = idle_hi ? high_ff : low_ff;
                            nxt_left = left_ff - 32'h1;
                        end
                    end else begin
                        nxt_gcnt = gcnt_ff - 32'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gst_ff <= cptm_pkg::GEN_IDLE;
            gcnt_ff <= cptm_pkg::RST_ZERO;
            left_ff <= cptm_pkg::RST_ZERO;
            out_ff <= 1'b0;
        end else begin
            gst_ff <= nxt_gst;
            gcnt_ff <= nxt_gcnt;
            left_ff <= nxt_left;
            out_ff <= nxt_out;
        end
    end
    assign ctr_out_o = out_ff;

    // APB slave: access phase with one wait state, error on unmapped address.
    logic acc;
    assign acc = psel_i & penable_i & ~pready_ff;
    assign start_req = acc & pwrite_i & (paddr_i == cptm_pkg::OFF_START);
    assign rd_result = acc & ~pwrite_i & (paddr_i == cptm_pkg::OFF_RESULT);

    always_comb begin
        logic hit;
        hit = 1'b1;
        nxt_ctrl = ctrl_ff;
        nxt_delay = delay_ff;
        nxt_high = high_ff;
        nxt_low = low_ff;
        nxt_count = count_ff;
        nxt_prdata = prdata_ff;
        nxt_pready = acc;
        nxt_pslverr = 1'b0;
        if (acc) begin
            nxt_prdata = 32'h0;
            unique case (paddr_i)
                cptm_pkg::OFF_CTRL: begin
                    nxt_prdata = {24'h0, ctrl_ff};
                    if (pwrite_i) begin
                        nxt_ctrl = pwdata_i[cptm_pkg::CTL_W-1:0];
                    end
                end
                cptm_pkg::OFF_STATUS: begin
                    nxt_prdata[cptm_pkg::ST_VALID] = valid_ff;
                    nxt_prdata[cptm_pkg::ST_BUSY] =
                        gst_ff != cptm_pkg::GEN_IDLE;
                    nxt_prdata[cptm_pkg::ST_OVF] = ovf_ff;
                end
                cptm_pkg::OFF_RESULT: begin
                    nxt_prdata = 32'(result_ff);
                end
                cptm_pkg::OFF_DELAY: begin
                    nxt_prdata = delay_ff;
                    if (pwrite_i) begin
                        nxt_delay = pwdata_i;
                    end
                end
                cptm_pkg::OFF_HIGH: begin
                    nxt_prdata = high_ff;
                    if (pwrite_i) begin
                        nxt_high = pwdata_i;
                    end
                end
                cptm_pkg::OFF_LOW: begin
                    nxt_prdata = low_ff;
                    if (pwrite_i) begin
                        nxt_low = pwdata_i;
                    end
                end
                cptm_pkg::OFF_COUNT: begin
                    nxt_prdata = count_ff;
                    if (pwrite_i) begin
                        nxt_count = pwdata_i;
                    end
                end
                cptm_pkg::OFF_START: begin
                    nxt_prdata = 32'h0;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            nxt_pslverr = ~hit;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_ff <= '0;
            delay_ff <= cptm_pkg::RST_ONE;
            high_ff <= cptm_pkg::RST_ONE;
            low_ff <= cptm_pkg::RST_ONE;
            count_ff <= cptm_pkg::RST_ONE;
            prdata_ff <= cptm_pkg::RST_ZERO;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            delay_ff <= nxt_delay;
            high_ff <= nxt_high;
            low_ff <= nxt_low;
            count_ff <= nxt_count;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end
    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;

    // Checks beside the logic.
    property p_idle_level;
        @(posedge clock_i) disable iff (!nrst_i)
        (gst_ff == cptm_pkg::GEN_IDLE && $past(gst_ff) ==
            cptm_pkg::GEN_IDLE) |-> out_ff == $past(idle_hi);
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("Output not at idle level while idle.");

    property p_active_level;
        @(posedge clock_i) disable iff (!nrst_i)
        $past(gst_ff == cptm_pkg::GEN_ACTIVE && nxt_gst ==
            cptm_pkg::GEN_ACTIVE) |-> out_ff == ~idle_hi;
    endproperty
    a_active_level: assert property (p_active_level)
        else $error("Output not at active level in pulse.");

    property p_start_delay;
        @(posedge clock_i) disable iff (!nrst_i)
        (gst_ff == cptm_pkg::GEN_IDLE && start_req) |=>
            gst_ff == cptm_pkg::GEN_DELAY && gcnt_ff == $past(delay_ff);
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("Start did not load the initial delay.");

    property p_capture;
        @(posedge clock_i) disable iff (!nrst_i)
        (ctrl_ff[cptm_pkg::CTL_MEAS_EN] && armed_ff && close_ev) |=>
            result_ff == (($past(tick) && $past(mcnt_ff) != '1) ?
            $past(mcnt_ff) + 1'b1 : $past(mcnt_ff)) && mcnt_ff == '0 &&
            valid_ff;
    endproperty
    a_capture: assert property (p_capture)
        else $error("Closing edge did not capture the count.");

    property p_count_tick;
        @(posedge clock_i) disable iff (!nrst_i)
        (ctrl_ff[cptm_pkg::CTL_MEAS_EN] && armed_ff && !close_ev &&
            !tick) |=> mcnt_ff == $past(mcnt_ff);
    endproperty
    a_count_tick: assert property (p_count_tick)
        else $error("Count moved without a timebase tick.");

    property p_apb_ready;
        @(posedge clock_i) disable iff (!nrst_i)
        (psel_i && penable_i && !pready_ff) |=> pready_ff ##1 !pready_ff;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("APB ready not given for exactly one cycle.");

    property p_train_end;
        @(posedge clock_i) disable iff (!nrst_i)
        (gst_ff == cptm_pkg::GEN_ACTIVE && tick && gcnt_ff <= 32'h1 &&
            left_ff > 32'h1) |=> gst_ff == cptm_pkg::GEN_REST;
    endproperty
    a_train_end: assert property (p_train_end)
        else $error("Train ended before its pulse count.");

    property p_sync;
        @(posedge clock_i) disable iff (!nrst_i)
        a_rise |-> $past(sync1_ff[0]) == 1'b1 &&
            $past(sync1_ff[0], 2) == 1'b0;
    endproperty
    a_sync: assert property (p_sync)
        else $error("Edge seen without passing the synchroniser.");
endmodule : cptm_top

// ### test/cptm_src.sv
// Signal source model that feeds the counter's measured inputs and timebase.
`timescale 1ns/1ps
module cptm_src (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [7:0] hi_len_i,
    input wire logic [7:0] lo_len_i,
    input wire logic [4:0] b_dly_i,
    input wire logic ext_en_i,
    output logic in_a_o,
    output logic in_b_o,
    output logic tb_o
);
    logic [7:0] ph;
    logic [31:0] hist;
    // Phase counter for A, history of A for B, and a timebase at half rate.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ph <= 8'h00;
            hist <= 32'h0000_0000;
            tb_o <= 1'b0;
        end else begin
            ph <= (ph + 8'h01 >= hi_len_i + lo_len_i) ? 8'h00 : ph + 8'h01;
            hist <= {hist[30:0], in_a_o};
            tb_o <= ext_en_i ? ~tb_o : 1'b0;
        end
    end
    // A is high for the first part of each phase; B lags A by b_dly clocks.
    assign in_a_o = (ph < hi_len_i);
    assign in_b_o = hist[b_dly_i - 5'h01];
endmodule // cptm_src

// ### test/cptm_top_test.sv
// Self-checking testbench of the counter block over its APB port.
`timescale 1ns/1ps
module cptm_top_test;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic in_a;
    logic in_b;
    logic ext_tb;
    logic ctr_out_o;
    logic [7:0] hi_len = 8'h05;
    logic [7:0] lo_len = 8'h09;
    logic [4:0] b_dly = 5'h03;
    logic ext_en = 1'b0;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic er;
    int w;

    always #2 clock_i = ~clock_i;

    cptm_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .in_a_i(in_a), .in_b_i(in_b),
        .ext_tb_i(ext_tb), .ctr_out_o(ctr_out_o));

    cptm_src src (.clock_i(clock_i), .nrst_i(nrst_i), .hi_len_i(hi_len),
        .lo_len_i(lo_len), .b_dly_i(b_dly), .ext_en_i(ext_en),
        .in_a_o(in_a), .in_b_o(in_b), .tb_o(ext_tb));

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Compares one value and counts the result.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        rd = prdata_o;
        er = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk(32'h0000_0000, 32'h0000_0001);
            final_report();
        end
    endtask

    // Waits for the output to reach a level; returns cycles waited in w.
    task automatic wait_lvl(input logic lvl);
        w = 0;
        while (ctr_out_o !== lvl && w < 300) begin
            @(posedge clock_i);
            w++;
        end
        if (w >= 300) begin
            chk(32'h0000_0000, 32'h0000_0001);
            final_report();
        end
    endtask

    // Measures how many cycles the output stays at a level.
    task automatic run_len(input logic lvl, input int exp);
        int n;
        n = 0;
        while (ctr_out_o === lvl && n < 300) begin
            @(posedge clock_i);
            n++;
        end
        chk(n, exp);
    endtask

    // Measures one configuration and checks the captured tick count.
    task automatic meas(input logic [7:0] ctl, input logic [7:0] hi,
        input logic [7:0] lo, input logic ex, input logic [31:0] exp);
        hi_len <= hi;
        lo_len <= lo;
        ext_en <= ex;
        apb(1'b1, cptm_pkg::OFF_CTRL, {24'h0, ctl});
        apb(1'b0, cptm_pkg::OFF_CTRL, 32'h0);
        chk(rd, {24'h0, ctl});
        repeat (60) @(posedge clock_i);
        apb(1'b0, cptm_pkg::OFF_RESULT, 32'h0);
        repeat (40) @(posedge clock_i);
        apb(1'b0, cptm_pkg::OFF_STATUS, 32'h0);
        chk({31'h0, rd[cptm_pkg::ST_VALID]}, 32'h1);
        apb(1'b0, cptm_pkg::OFF_RESULT, 32'h0);
        chk(rd, exp);
        $display("test meas ctl %h end", ctl);
    endtask

    // Generation: delay 10, high 2, low 4, two pulses, START given twice.
    task automatic gen(input logic idle_hi);
        int a;
        int r;
        a = idle_hi ? 4 : 2;
        r = idle_hi ? 2 : 4;
        apb(1'b1, cptm_pkg::OFF_CTRL, {26'h0, idle_hi, 5'h0});
        repeat (5) @(posedge clock_i);
        chk(ctr_out_o, idle_hi);
        apb(1'b1, cptm_pkg::OFF_START, 32'h1);
        apb(1'b1, cptm_pkg::OFF_START, 32'h1);
        apb(1'b0, cptm_pkg::OFF_STATUS, 32'h0);
        chk({31'h0, rd[cptm_pkg::ST_BUSY]}, 32'h1);
        wait_lvl(~idle_hi);
        chk(w >= 2, 32'h1);
        run_len(~idle_hi, a);
        run_len(idle_hi, r);
        run_len(~idle_hi, a);
        repeat (30) begin
            @(posedge clock_i);
            if (ctr_out_o !== idle_hi) w = -1;
        end
        chk(w == -1, 32'h0);
        apb(1'b0, cptm_pkg::OFF_STATUS, 32'h0);
        chk({31'h0, rd[cptm_pkg::ST_BUSY]}, 32'h0);
        $display("test gen idle %b end", idle_hi);
    endtask

    // Main sequence.
    initial begin
        repeat (8) @(posedge clock_i);
        nrst_i <= 1'b1;
        chk(ctr_out_o, 1'b0);
        apb(1'b1, cptm_pkg::OFF_STATUS, 32'hffff_ffff);
        apb(1'b1, cptm_pkg::OFF_RESULT, 32'hffff_ffff);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, (i >= 3 && i <= 6) ? cptm_pkg::RST_ONE
                : cptm_pkg::RST_ZERO);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        $display("test reset end");
        meas(8'h80, 8'h05, 8'h09, 1'b0, 32'd14);
        meas(8'h88, 8'h05, 8'h09, 1'b0, 32'd14);
        meas(8'h81, 8'h07, 8'h07, 1'b0, 32'd7);
        meas(8'h82, 8'h05, 8'h09, 1'b0, 32'd5);
        meas(8'h8a, 8'h05, 8'h09, 1'b0, 32'd9);
        meas(8'h83, 8'h05, 8'h09, 1'b0, 32'd3);
        meas(8'h8b, 8'h05, 8'h09, 1'b0, 32'd12);
        meas(8'h93, 8'h05, 8'h09, 1'b0, 32'd8);
        meas(8'hc0, 8'h05, 8'h09, 1'b1, 32'd7);
        ext_en <= 1'b0;
        apb(1'b1, cptm_pkg::OFF_DELAY, 32'd10);
        apb(1'b1, cptm_pkg::OFF_HIGH, 32'd2);
        apb(1'b1, cptm_pkg::OFF_LOW, 32'd4);
        apb(1'b1, cptm_pkg::OFF_COUNT, 32'd2);
        gen(1'b0);
        gen(1'b1);
        final_report();
    end
endmodule // cptm_top_test
